// ==== bench/gims_slave_model.sv ====
// behavioural two-wire slave standing in for the positioning receiver
`timescale 1ns/1ns
`default_nettype none
module gims_slave_model #(
  parameter logic [6:0] ADDR = 7'h42  // bus address, value arbitrary
) (
  input  wire logic scl,      // clock line level
  input  wire logic sda,      // data line level
  input  wire logic slow,     // stretch every low phase while active
  output logic      sclHold,  // pulls clock low
  output logic      sdaPull   // pulls data low
);
  logic       active, isAddr, rd, skip, nack;
  logic [7:0] sh, tx, dataReg;
  int         cnt;

  initial begin
    {active, isAddr, rd, skip, nack, sclHold, sdaPull} = '0;
    {sh, tx, dataReg} = '0;
    cnt = 0;
  end
  always @(negedge sda) if (scl === 1'b1) begin
    {active, isAddr, skip} = 3'h7;
    cnt = 0;
    tx = dataReg;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    active = 1'b0;
    sdaPull = 1'b0;
  end
  always @(posedge scl) if (active) begin
    if (cnt < 8) sh = {sh[6:0], sda};
    else nack = sda;
  end
  // bit bookkeeping; reads return the last written byte, then counting up
  always @(negedge scl) if (active) begin
    if (skip) skip = 1'b0;
    else if (cnt == 8) begin
      cnt = 0;
      if (!isAddr && rd) tx = tx + 8'h01;
      if (!isAddr && rd && nack) active = 1'b0;
      isAddr = 1'b0;
    end else cnt = cnt + 1;
    sdaPull = 1'b0;
    if (cnt == 8 && isAddr && sh[7:1] != ADDR) active = 1'b0;
    else if (cnt == 8 && (isAddr || !rd)) begin
      sdaPull = 1'b1;
      if (isAddr) rd = sh[0];
      else dataReg = sh;
    end else if (cnt < 8 && active && rd && !isAddr) sdaPull = !tx[7 - cnt];
  end
  always @(negedge scl) if (active && slow) begin
    sclHold = 1'b1;
    #6000;
    sclHold = 1'b0;
  end
endmodule  // gims_slave_model
`default_nettype wire

// ==== bench/tb_gims_i2c_master.sv ====
// self-checking bench for the two-wire master and its sidebands
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin nChecks++; if ((a) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb_gims_i2c_master;
  import gims_pkg::*;
  localparam logic [6:0] SLV = 7'h42;
  logic sys_clk, rst_b, cmdValid, cmdReady, doneValid, rdValid, rdReady;
  logic sclOut, sclOe, sdaOut, sdaOe, sclHold, sdaPull, slow, holdRd, live;
  logic power_saving_command, supplyOn, receiver_supply_enable_pin;
  logic receiver_data_ready_pin, wakePulse, idleMode, rtcShareEn, rtcTick;
  logic rtc_sync_out_pin, aidingEn, aidCapture, aidClear, restoreReq, restoreAck;
  logic supPrev, rtcPrev;
  logic [7:0]    rdData, aidRdData, b0, b1;
  logic [4:0]    aidCount;
  logic [3:0]    aidRdIdx;
  logic [31:0]   lfsr;
  gims_cmd_type  cmd;
  gims_done_type done;
  logic [1:0]    expDone[$];
  logic [7:0]    expRd[$];
  int            failures, nChecks;
  wire logic     sclIn = !(sclOe | sclHold);
  wire logic     sdaIn = !(sdaOe | sdaPull);

  gims_i2c_master dut (.sys_clk, .rst_b, .cmdValid, .cmdReady, .cmd, .done, .doneValid,
    .rdValid, .rdReady, .rdData, .sclIn, .sclOut, .sclOe, .sdaIn, .sdaOut, .sdaOe,
    .power_saving_command, .supplyOn, .receiver_supply_enable_pin,
    .receiver_data_ready_pin, .wakePulse, .idleMode, .rtcShareEn, .rtcTick,
    .rtc_sync_out_pin, .aidingEn, .aidCapture, .aidClear, .aidRdIdx, .aidRdData,
    .aidCount, .restoreReq, .restoreAck);
  gims_slave_model #(.ADDR(SLV)) slv (.scl(sclIn), .sda(sdaIn), .slow(slow),
    .sclHold(sclHold), .sdaPull(sdaPull));

  always #10 sys_clk = ~sys_clk;
  initial begin
    rtcTick = 1'b0;
    #7;
    forever #80 rtcTick = ~rtcTick;
  end

  function automatic logic [31:0] nextRnd(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic tick();
    @(posedge sys_clk);
    #1;
    lfsr = nextRnd(lfsr);
    rdReady = holdRd ? 1'b0 : lfsr[0];
  endtask

  // offer a command and hold it until the edge that takes it
  task automatic doCmd(gims_op_type op, logic [7:0] d, logic lst, logic [1:0] exp);
    logic r;
    int n;
    cmd = '{op, d, lst};
    cmdValid = 1'b1;
    expDone.push_back(exp);
    n = 0;
    do begin
      r = cmdReady;
      tick();
      n++;
    end while (r !== 1'b1 && n < 20000);
    if (r !== 1'b1) begin
      failures++;
      report_and_stop();
    end
  endtask

  task automatic drain(int keep);
    int n;
    cmdValid = 1'b0;
    n = 0;
    do begin
      tick();
      n++;
    end while ((expDone.size() != 0 || expRd.size() > keep) && n < 30000);
    if (expDone.size() != 0 || expRd.size() > keep) begin
      failures++;
      report_and_stop();
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // results are taken off the queues in the order they were noted
  always @(posedge sys_clk) begin
    if (doneValid === 1'b1) `CHK(done, expDone.pop_front())
    if (rdValid === 1'b1 && rdReady === 1'b1) `CHK(rdData, expRd.pop_front())
    if (live) begin
      `CHK(receiver_supply_enable_pin, supPrev)
      `CHK(rtc_sync_out_pin, rtcPrev)
    end
    supPrev = supplyOn;
    rtcPrev = rtcShareEn & rtcTick;
  end

  initial begin
    #1500000;
    failures++;
    report_and_stop();
  end

  initial begin
    logic seen;
    {sys_clk, rst_b, cmdValid, rdReady, holdRd, slow, live, supPrev, rtcPrev} = '0;
    {power_saving_command, supplyOn, receiver_data_ready_pin} = '0;
    {aidCapture, aidClear, restoreAck} = '0;
    {rtcShareEn, aidingEn} = 2'h3;
    aidRdIdx = 4'h0;
    cmd = '0;
    lfsr = 32'hC3DB;
    failures = 0;
    nChecks = 0;
    repeat (20) tick();
    rst_b = 1'b1;
    tick();
    live = 1'b1;
    supplyOn = 1'b1;
    doCmd(OP_WRITE, 8'h5A, 1'b0, 2'b00);
    doCmd(OP_STOP, 8'h00, 1'b0, 2'b10);
    doCmd(OP_START, {~SLV, 1'b0}, 1'b0, 2'b00);
    doCmd(OP_STOP, 8'h00, 1'b0, 2'b10);
    b0 = lfsr[15:8];
    b1 = lfsr[23:16];
    slow = 1'b1;
    doCmd(OP_START, {SLV, 1'b0}, 1'b0, 2'b10);
    doCmd(OP_WRITE, b0, 1'b0, 2'b10);
    doCmd(OP_WRITE, b1, 1'b0, 2'b10);
    drain(0);
    slow = 1'b0;
    holdRd = 1'b1;
    aidCapture = 1'b1;
    doCmd(OP_START, {SLV, 1'b1}, 1'b0, 2'b10);
    for (int i = 0; i < 2; i++) begin
      doCmd(OP_READ, 8'h00, 1'b0, 2'b11);
      expRd.push_back(b1 + 8'(i));
    end
    drain(2);
    // buffer full: a further read must wait, losing nothing
    cmd = '{OP_READ, 8'h00, 1'b1};
    cmdValid = 1'b1;
    repeat (30) tick();
    `CHK(cmdReady, 1'b0)
    holdRd = 1'b0;
    doCmd(OP_READ, 8'h00, 1'b1, 2'b11);
    expRd.push_back(b1 + 8'h02);
    doCmd(OP_STOP, 8'h00, 1'b0, 2'b10);
    drain(0);
    aidCapture = 1'b0;
    `CHK(aidCount, 5'h03)
    `CHK(aidRdData, b1)
    `CHK({sclOe, sdaOe, sclOut, sdaOut}, 4'h0)
    supplyOn = 1'b0;
    rtcShareEn = 1'b0;
    repeat (3) tick();
    supplyOn = 1'b1;
    repeat (3) tick();
    `CHK(restoreReq, 1'b1)
    restoreAck = 1'b1;
    repeat (2) tick();
    `CHK(restoreReq, 1'b0)
    restoreAck = 1'b0;
    aidClear = 1'b1;
    repeat (2) tick();
    `CHK(aidCount, 5'h00)
    aidClear = 1'b0;
    // an empty store asks for no restore at the next power-up
    supplyOn = 1'b0;
    repeat (3) tick();
    supplyOn = 1'b1;
    repeat (3) tick();
    `CHK(restoreReq, 1'b0)
    power_saving_command = 1'b1;
    repeat (8) tick();
    `CHK(idleMode, 1'b1)
    receiver_data_ready_pin = 1'b1;
    seen = 1'b0;
    repeat (6) begin
      tick();
      seen = seen | (wakePulse === 1'b1);
    end
    `CHK(seen, 1'b1)
    `CHK(idleMode, 1'b0)
    report_and_stop();
  end
endmodule  // tb_gims_i2c_master
`default_nettype wire

// ==== src/gims_fifo2.sv ====
// small valid/ready buffer on the received data path
`timescale 1ns/1ns
`default_nettype none
module gims_fifo2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             sys_clk,   // system clock
  input  wire logic             rst_b,     // synchronous reset, active low
  input  wire logic             inValid,   // word offered
  output logic                  inReady,   // room for a word
  input  wire logic [WIDTH-1:0] inData,    // word in
  output logic                  outValid,  // word available
  input  wire logic             outReady,  // drain accepts
  output logic      [WIDTH-1:0] outData    // oldest word
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             doPush;
  logic             doPop;

  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;

  always_ff @(posedge sys_clk) begin
    if (doPush) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doPush) begin
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (doPop) begin
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
      count <= count + (AW+1)'(doPush) - (AW+1)'(doPop);
    end
  end

  count_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    count <= (AW+1)'(DEPTH)) else $error("buffer count above depth");
endmodule // gims_fifo2
`default_nettype wire

// ==== src/gims_i2c_master.sv ====
// two-wire bus master with receiver supply, data-ready wake and clock-sync sidebands
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// R01: device is bus master only, never slave
// R02: receiver and peripherals answer as slaves only
// R03: clock times each bit, data line carries bits
// R04: both lines open-drain, external pull-ups
// R05: bus bytes never interpreted as commands
// R06: host command removes receiver supply
// R07: receiver raises data-ready when data waits
// R08: data-ready wakes module, no data lost
// R09: power saving and quiet bus enter idle
// R10: drive clock-sync pin when sharing enabled
// R11: capture aiding data, request restore at power-up
// R12: start, address, acknowledged bytes, then stop
module gims_i2c_master #(
  parameter int BUF_DEPTH = 2,
  parameter int AID_WORDS = gims_pkg::AID_DEPTH
) (
  input  wire logic                   sys_clk,                    // 50 MHz clock
  input  wire logic                   rst_b,                      // sync reset, low
  input  wire logic                   cmdValid,                   // command offered
  output logic                        cmdReady,                   // command taken
  input  wire gims_pkg::gims_cmd_type cmd,                        // command word
  output gims_pkg::gims_done_type     done,                       // result of command
  output logic                        doneValid,                  // result pulse
  output logic                        rdValid,                    // read byte ready
  input  wire logic                   rdReady,                    // read byte taken
  output logic [7:0]                  rdData,                     // read byte
  input  wire logic                   sclIn,                      // clock line level
  output logic                        sclOut,                     // clock drive value
  output logic                        sclOe,                      // clock pulled low
  input  wire logic                   sdaIn,                      // data line level
  output logic                        sdaOut,                     // data drive value
  output logic                        sdaOe,                      // data pulled low
  input  wire logic                   power_saving_command,       // power saving on
  input  wire logic                   supplyOn,                   // host wants supply
  output logic                        receiver_supply_enable_pin, // receiver supply
  input  wire logic                   receiver_data_ready_pin,    // receiver has data
  output logic                        wakePulse,                  // wake from idle
  output logic                        idleMode,                   // idle allowed
  input  wire logic                   rtcShareEn,                 // sync sharing on
  input  wire logic                   rtcTick,                    // local clock-sync
  output logic                        rtc_sync_out_pin,           // sync to receiver
  input  wire logic                   aidingEn,                   // local aiding on
  input  wire logic                   aidCapture,                 // store read bytes
  input  wire logic                   aidClear,                   // empty aiding store
  input  wire logic [$clog2(AID_WORDS)-1:0] aidRdIdx,             // aiding read index
  output logic [7:0]                  aidRdData,                  // aiding word
  output logic [$clog2(AID_WORDS):0]  aidCount,                   // words stored
  output logic                        restoreReq,                 // restore pending
  input  wire logic                   restoreAck                  // restore done
);
  import gims_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_HOLD = 4'h1,
    S_ST1  = 4'h2,
    S_ST2  = 4'h3,
    S_ST3  = 4'h4,
    S_BITL = 4'h5,
    S_BITD = 4'h6,
    S_BITH = 4'h7,
    S_SP1  = 4'h8,
    S_SP2  = 4'h9
  } gims_state_type;

  gims_state_type state;
  logic [8:0]     tmr;
  logic [8:0]     txShift;
  logic [8:0]     rxShift;
  logic [3:0]     bitCnt;
  logic           isRead;
  logic           sclMeta, sclSync;
  logic           sdaMeta, sdaSync;
  logic           drdyMeta, drdySync, drdyPrev;
  logic           supplyPrev;
  logic           bufInValid, bufInReady;
  logic [7:0]     bufInData;
  logic           tick;
  logic           take;
  logic [7:0]     aidMem [AID_WORDS];

  // pins are open-drain: drive value is always low, enables pull
  assign sclOut = 1'b0;  // R04
  assign sdaOut = 1'b0;  // R04
  assign tick   = (tmr == 9'h000);

  // reads are only taken when the buffer can hold the byte; a byte still
  // being pushed counts as stored, or a full buffer would drop the next one
  assign cmdReady = ((state == S_IDLE) || (state == S_HOLD)) &&
                    ((cmd.op != OP_READ) || (bufInReady && !bufInValid));  // R08
  assign take     = cmdValid && cmdReady;

  // two-stage synchronisers for everything arriving from pins
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sclMeta  <= 1'b1;
      sclSync  <= 1'b1;
      sdaMeta  <= 1'b1;
      sdaSync  <= 1'b1;
      drdyMeta <= 1'b0;
      drdySync <= 1'b0;
      drdyPrev <= 1'b0;
    end else begin
      sclMeta  <= sclIn;
      sclSync  <= sclMeta;
      sdaMeta  <= sdaIn;
      sdaSync  <= sdaMeta;
      drdyMeta <= receiver_data_ready_pin;
      drdySync <= drdyMeta;
      drdyPrev <= drdySync;
    end
  end

  // bit engine; the module only ever originates transfers, no slave path
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state      <= S_IDLE;
      tmr        <= 9'h000;
      txShift    <= 9'h1FF;
      rxShift    <= 9'h000;
      bitCnt     <= 4'h0;
      isRead     <= 1'b0;
      sclOe      <= 1'b0;
      sdaOe      <= 1'b0;
      doneValid  <= 1'b0;
      done       <= '0;
      bufInValid <= 1'b0;
      bufInData  <= 8'h00;
    end else begin
      doneValid  <= 1'b0;
      bufInValid <= 1'b0;
      tmr        <= tick ? 9'h000 : tmr - 9'h001;
      case (state)
        S_IDLE, S_HOLD: begin
          if (take) begin  // R01
            bitCnt  <= 4'h0;
            tmr     <= QUARTER_CYC;
            isRead  <= (cmd.op == OP_READ);
            // data bytes pass through untouched
            txShift <= (cmd.op == OP_READ) ? {8'hFF, cmd.last} : {cmd.data, 1'b1};  // R05
            case (cmd.op)
              OP_START: state <= (state == S_IDLE) ? S_ST2 : S_ST1;  // R12
              OP_STOP: begin
                if (state == S_HOLD) begin
                  state <= S_SP1;
                  sdaOe <= 1'b1;
                end else begin
                  doneValid <= 1'b1;
                  done      <= '{ackOk: 1'b1, wasRead: 1'b0};
                end
              end
              default: begin
                if (state == S_HOLD) begin
                  state <= S_BITL;
                end else begin
                  doneValid <= 1'b1;
                  done      <= '{ackOk: 1'b0, wasRead: 1'b0};
                end
              end
            endcase
          end
        end
        S_ST1: begin
          sdaOe <= 1'b0;
          if (tick) begin
            state <= S_ST2;
            sclOe <= 1'b0;
            tmr   <= QUARTER_CYC;
          end
        end
        S_ST2: begin
          if (!sclSync) begin
            tmr <= QUARTER_CYC;
          end else if (tick) begin
            state <= S_ST3;
            sdaOe <= 1'b1;  // R12
            tmr   <= QUARTER_CYC;
          end
        end
        S_ST3: begin
          if (tick) begin
            state <= S_BITL;
            sclOe <= 1'b1;
            tmr   <= QUARTER_CYC;
          end
        end
        S_BITL: begin
          sclOe <= 1'b1;
          if (tick) begin
            state <= S_BITD;
            sdaOe <= !txShift[8];  // R03
            tmr   <= QUARTER_CYC;
          end
        end
        S_BITD: begin
          if (tick) begin
            state <= S_BITH;
            sclOe <= 1'b0;
            tmr   <= HALF_CYC;
          end
        end
        S_BITH: begin
          // a slave holding the clock low delays the high phase
          if (!sclSync) begin
            tmr <= HALF_CYC;
          end else if (tick) begin
            rxShift <= {rxShift[7:0], sdaSync};  // R03
            txShift <= {txShift[7:0], 1'b1};
            bitCnt  <= bitCnt + 4'h1;
            sclOe   <= 1'b1;
            tmr     <= QUARTER_CYC;
            if (bitCnt == LAST_BIT) begin
              state      <= S_HOLD;
              doneValid  <= 1'b1;  // R12
              done       <= '{ackOk: isRead | !sdaSync, wasRead: isRead};
              bufInValid <= isRead;
              bufInData  <= rxShift[7:0];
            end else begin
              state <= S_BITL;
            end
          end
        end
        S_SP1: begin
          if (tick) begin
            state <= S_SP2;
            sclOe <= 1'b0;
            tmr   <= QUARTER_CYC;
          end
        end
        S_SP2: begin
          if (!sclSync) begin
            tmr <= QUARTER_CYC;
          end else if (tick) begin
            state     <= S_IDLE;
            sdaOe     <= 1'b0;  // R12
            doneValid <= 1'b1;
            done      <= '{ackOk: 1'b1, wasRead: 1'b0};
          end
        end
        default: begin
          state <= S_IDLE;
          sclOe <= 1'b0;
          sdaOe <= 1'b0;
        end
      endcase
    end
  end

  gims_fifo2 #(.WIDTH(8), .DEPTH(BUF_DEPTH)) rxBuf (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .inValid  (bufInValid),
    .inReady  (bufInReady),
    .inData   (bufInData),
    .outValid (rdValid),
    .outReady (rdReady),
    .outData  (rdData)
  );

  // sidebands: supply, wake, idle and clock sharing
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      receiver_supply_enable_pin <= SUPPLY_RESET;
      rtc_sync_out_pin           <= RTC_RESET;
      wakePulse                  <= 1'b0;
      idleMode                   <= 1'b0;
    end else begin
      receiver_supply_enable_pin <= supplyOn;  // R06
      rtc_sync_out_pin           <= rtcShareEn & rtcTick;  // R10
      wakePulse                  <= drdySync & !drdyPrev;  // R08
      idleMode                   <= power_saving_command && (state == S_IDLE) &&
                                    !drdySync && !cmdValid && !rdValid;  // R09
    end
  end

  // aiding store: read bytes captured, restore asked on receiver power-up
  always_ff @(posedge sys_clk) begin
    if (bufInValid && aidCapture && (aidCount != ($clog2(AID_WORDS)+1)'(AID_WORDS))) begin
      aidMem[aidCount[$clog2(AID_WORDS)-1:0]] <= bufInData;  // R11
    end
  end

  assign aidRdData = aidMem[aidRdIdx];

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      aidCount   <= '0;
      restoreReq <= 1'b0;
      supplyPrev <= SUPPLY_RESET;
    end else begin
      supplyPrev <= receiver_supply_enable_pin;
      if (aidClear) begin
        aidCount <= '0;
      end else if (bufInValid && aidCapture &&
                   (aidCount != ($clog2(AID_WORDS)+1)'(AID_WORDS))) begin
        aidCount <= aidCount + 1'b1;
      end
      // a new power-up wins over an acknowledge in the same cycle
      if (receiver_supply_enable_pin && !supplyPrev && aidingEn && (aidCount != '0)) begin
        restoreReq <= 1'b1;  // R11
      end else if (restoreAck) begin
        restoreReq <= 1'b0;
      end
    end
  end

  tx_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R03
    (state == S_BITH) |=> $stable(sdaOe)) else $error("data moved while clock high");
  od_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R04
    !sclOut && !sdaOut) else $error("line driven high");
  idle_bus_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R01
    (state == S_IDLE) && $past(state) == S_IDLE |-> !sclOe && !sdaOe)
    else $error("bus held while idle");
  start_cond_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R12
    $rose(sdaOe) && !sclOe |-> state == S_ST3) else $error("stray start");
  stop_cond_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R12
    $fell(sdaOe) && !sclOe |-> state == S_IDLE ##0 doneValid)
    else $error("stray stop");
  supply_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R06
    !supplyOn |=> !receiver_supply_enable_pin) else $error("supply not removed");
  wake_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R08
    $rose(drdySync) |=> wakePulse ##1 !wakePulse) else $error("wake missing");
  idle_entry_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R09
    idleMode |-> $past(power_saving_command) && !$past(drdySync))
    else $error("idle without cause");
  rtc_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R10
    !rtcShareEn |=> !rtc_sync_out_pin) else $error("sync without sharing");
  restore_req_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R11
    $rose(receiver_supply_enable_pin) && aidingEn && (aidCount != '0) |=> restoreReq)
    else $error("restore not requested");

  start_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
    state == S_ST3 ##1 state == S_BITL);
  read_full_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
    cmdValid && (cmd.op == OP_READ) && (state == S_HOLD) && !cmdReady);
  wake_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
    idleMode ##1 wakePulse);
endmodule // gims_i2c_master
`default_nettype wire

// ==== src/gims_pkg.sv ====
// shared constants and types for the positioning-receiver two-wire master
package gims_pkg;

  // bus timing: a quarter of a standard-mode bit period
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned QUARTER_NS    = 2500;
  localparam logic [8:0]  QUARTER_CYC   =
    9'((QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [8:0]  HALF_CYC      = 9'(2 * QUARTER_CYC);

  // index of the last bit of a bus byte: the acknowledge slot, nine bits counted 0 to 8
  localparam logic [3:0]  LAST_BIT      = 4'h8;

  // reset values of the sideband outputs
  localparam logic        SUPPLY_RESET  = 1'b0;
  localparam logic        RTC_RESET     = 1'b0;

  // depth of the aiding store
  localparam int unsigned AID_DEPTH     = 16;

  typedef enum logic [1:0] {
    OP_START = 2'b00,   // start or repeated start, data is address and direction
    OP_WRITE = 2'b01,
    OP_READ  = 2'b10,
    OP_STOP  = 2'b11
  } gims_op_type;

  typedef struct packed {
    gims_op_type op;
    logic [7:0]  data;
    logic        last;  // read: answer this byte with no acknowledge
  } gims_cmd_type;

  typedef struct packed {
    logic ackOk;
    logic wasRead;
  } gims_done_type;

endpackage
